// ### spl_pkg.sv
package spl_pkg;
    // ----------------------------------------
    // command opcodes
    // ----------------------------------------
    localparam logic [7:0]  OP_WREN    = 8'h06;
    localparam logic [7:0]  OP_WRDI    = 8'h04;
    localparam logic [7:0]  OP_WRSR1   = 8'h01;
    localparam logic [7:0]  OP_WRSR2   = 8'h31;
    localparam logic [7:0]  OP_PROT    = 8'h36;
    localparam logic [7:0]  OP_UNPROT  = 8'h39;
    localparam logic [7:0]  OP_LOCKDN  = 8'h33;
    localparam logic [7:0]  OP_FREEZE  = 8'h34;
    localparam logic [7:0]  CONFIRM    = 8'hD0;
    localparam logic [23:0] FREEZE_ADR = 24'h55AA40;
    // ----------------------------------------
    // status fields
    // ----------------------------------------
    localparam int          PROTECTION_REGS_LOCKED_BIT_BIT   = 7;
    localparam int          GP_LSB     = 2;
    localparam int          GP_W       = 4;
    localparam int          SLE_BIT    = 4;
    localparam logic [3:0]  GP_UNPROT  = 4'h0;
    localparam logic [3:0]  GP_PROT    = 4'hF;
    localparam int          SECT_LSB   = 16;
    // ----------------------------------------
    // framing, byte counts and bit positions
    // ----------------------------------------
    localparam logic [2:0]  NB_OP      = 3'h1;
    localparam logic [2:0]  NB_DATA    = 3'h2;
    localparam logic [2:0]  NB_ADDR    = 3'h4;
    localparam logic [2:0]  NB_CONF    = 3'h5;
    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [2:0]  BIT_ZERO   = 3'h0;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic        PROT_RST   = 1'b1;
    localparam logic        PROTECTION_REGS_LOCKED_BIT_RST   = 1'b0;
    localparam int          CLK_MHZ    = 100;
    localparam int          LOCK_US    = 200;
    typedef enum logic [1:0] {
        SPL_IDLE = 2'b00,
        SPL_XFER = 2'b01,
        SPL_BUSY = 2'b10
    } spl_state_t;
endpackage

// ### spl_lockdown.sv
// Summary of operation
// - hardware lock active only with write-protect asserted and lock bit one
// - hardware lock ignores sector protect, unprotect and status byte one writes
// - sector protected exactly when its bit is one, pin irrelevant
// - clearing the lock bit never performs a global protect operation
// - lock bit is volatile and resets to zero
// - setting the lock bit also performs the selected global operation
// - lock bit zero accepts sector and global commands and setting it
// - software lock ignores sector and global commands, allows clearing
// - one nonvolatile lockdown bit per 64KB sector survives resets
// - a set lockdown bit blocks program and erase of its sector
// - lockdown bits only go from zero to one
// - lockdown frame is 33h, three address bytes, D0h, rest ignored
// - valid lockdown sets sector bit at chip select rise, clears write enable
// - short frame, bad confirm or off-boundary release aborts, clears write enable
// - disabled or frozen lockdown is ignored and clears write enable
// - freeze 34h, 55AA40h, D0h clears lockdown enable permanently
// - status byte one stores bit seven, bits five to two select global
module spl_lockdown
    import spl_pkg::*;
#(
    parameter int          SECT_W      = 4,
    parameter int unsigned LOCK_CYCLES = LOCK_US * CLK_MHZ
) (
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   mosi,
    input  wire logic                   wp_n,
    input  wire logic [(1<<SECT_W)-1:0] nv_lockdown_in,
    input  wire logic                   nv_frozen_in,
    input  wire logic [SECT_W-1:0]      pe_sector,
    output logic [(1<<SECT_W)-1:0]      sector_prot,
    output logic [(1<<SECT_W)-1:0]      lockdown_bits,
    output logic                        frozen,
    output logic                        write_enable_latch,
    output logic                        protection_regs_locked_bit,
    output logic                        lockdown_enable_bit,
    output logic                        hw_locked,
    output logic                        sw_locked,
    output logic                        busy,
    output logic                        pe_allowed
);
    localparam int NSECT = 1 << SECT_W;

    function automatic logic [SECT_W-1:0] sect_of(input logic [23:0] a);
        return a[SECT_LSB +: SECT_W];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] sclk_r;
    logic [2:0] cs_r;
    logic [1:0] mosi_r;
    logic [1:0] wp_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_r <= 3'h0;
            cs_r   <= 3'h7;
            mosi_r <= 2'h0;
            wp_r   <= 2'h3;
        end else begin
            sclk_r <= {sclk_r[1:0], sclk};
            cs_r   <= {cs_r[1:0], cs_n};
            mosi_r <= {mosi_r[0], mosi};
            wp_r   <= {wp_r[0], wp_n};
        end
    end
    wire sclk_rise = sclk_r[1] & ~sclk_r[2];
    wire cs_fall   = ~cs_r[1] & cs_r[2];
    wire cs_rise   = cs_r[1] & ~cs_r[2];
    wire wp_act    = ~wp_r[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    spl_state_t        st_r, st_nxt;
    logic [2:0]        bit_r, nb_r;
    logic [7:0]        sh_r, op_r, data_r, conf_r;
    logic [23:0]       addr_r;
    logic [31:0]       cnt_r;
    logic              loaded_r, wel_r, protection_regs_locked_bit_r, sle_r, frozen_r, pe_r;
    logic [NSECT-1:0]  prot_r, lock_r;
    logic              wel_nxt, protection_regs_locked_bit_nxt, sle_nxt, frozen_nxt;
    logic [NSECT-1:0]  prot_nxt, lock_nxt;

    // ----------------------------------------
    // decode at chip select release
    // ----------------------------------------
    wire       shifting  = (st_r == SPL_XFER) & sclk_rise & ~cs_r[1];
    wire       byte_done = shifting & (bit_r == BIT_LAST);
    wire [7:0] byte_val  = {sh_r[6:0], mosi_r[1]};
    wire       exec      = (st_r == SPL_XFER) & cs_rise;
    wire       bound     = (bit_r == BIT_ZERO);
    wire       fr_data   = bound & (nb_r >= NB_DATA);
    wire       fr_addr   = bound & (nb_r >= NB_ADDR);
    wire       fr_conf   = bound & (nb_r >= NB_CONF) & (conf_r == CONFIRM);
    wire       hw_lk     = wp_act & protection_regs_locked_bit_r;
    wire       sw_lk     = ~wp_act & protection_regs_locked_bit_r;
    wire       op_sect   = (op_r == OP_PROT) | (op_r == OP_UNPROT);
    wire       op_wr     = (op_r == OP_WRSR1) | (op_r == OP_WRSR2) | op_sect
                         | (op_r == OP_LOCKDN) | (op_r == OP_FREEZE);
    wire       sr1_go    = exec & (op_r == OP_WRSR1) & wel_r & fr_data & ~hw_lk;
    wire       gp_go     = sr1_go & ~protection_regs_locked_bit_r;
    wire [3:0] gp_code   = data_r[GP_LSB +: GP_W];
    wire       sect_go   = exec & op_sect & wel_r & fr_addr & ~protection_regs_locked_bit_r;
    wire       sr2_go    = exec & (op_r == OP_WRSR2) & wel_r & fr_data;
    wire       lk_en     = sle_r & ~frozen_r;
    wire       lock_go   = exec & (op_r == OP_LOCKDN) & lk_en & wel_r & fr_conf;
    wire       frz_go    = exec & (op_r == OP_FREEZE) & lk_en & wel_r & fr_conf
                         & (addr_r == FREEZE_ADR);
    wire [NSECT-1:0] sect_oh = {{(NSECT-1){1'b0}}, 1'b1} << sect_of(addr_r);

    always_comb begin
        wel_nxt = wel_r;
        if (exec && op_r == OP_WREN && nb_r == NB_OP && bound)
            wel_nxt = 1'b1;
        else if (exec && (op_wr || op_r == OP_WRDI))
            wel_nxt = 1'b0;
    end

    // global operation only when the lock bit was clear before the write
    always_comb begin
        protection_regs_locked_bit_nxt = sr1_go ? data_r[PROTECTION_REGS_LOCKED_BIT_BIT] : protection_regs_locked_bit_r;
        prot_nxt = prot_r;
        if (gp_go && gp_code == GP_PROT)
            prot_nxt = {NSECT{1'b1}};
        else if (gp_go && gp_code == GP_UNPROT)
            prot_nxt = {NSECT{1'b0}};
        if (sect_go)
            prot_nxt = (op_r == OP_PROT) ? (prot_r | sect_oh) : (prot_r & ~sect_oh);
    end

    always_comb begin
        lock_nxt   = lock_r | (lock_go ? sect_oh : {NSECT{1'b0}});
        frozen_nxt = frozen_r | frz_go;
        sle_nxt    = sle_r;
        if (frz_go)
            sle_nxt = 1'b0;
        else if (sr2_go)
            sle_nxt = data_r[SLE_BIT] & ~frozen_r;
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SPL_IDLE: begin
                if (cs_fall && loaded_r)
                    st_nxt = SPL_XFER;
            end
            SPL_XFER: begin
                if (exec)
                    st_nxt = (lock_go || frz_go) ? SPL_BUSY : SPL_IDLE;
            end
            SPL_BUSY: begin
                if (cnt_r == 32'h0)
                    st_nxt = SPL_IDLE;
            end
            default: st_nxt = SPL_IDLE;
        endcase
    end

    // ----------------------------------------
    // shifter and framing
    // ----------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_r <= 3'h0;
            nb_r  <= 3'h0;
            sh_r  <= 8'h00;
        end else if (st_r == SPL_IDLE) begin
            bit_r <= 3'h0;
            nb_r  <= 3'h0;
        end else if (shifting) begin
            bit_r <= bit_r + 3'h1;
            sh_r  <= byte_val;
            if (byte_done && nb_r != NB_CONF)
                nb_r <= nb_r + 3'h1; // extra bytes ignored
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            op_r   <= 8'h00;
            data_r <= 8'h00;
            conf_r <= 8'h00;
            addr_r <= 24'h0;
        end else if (byte_done) begin
            if (nb_r == 3'h0)
                op_r <= byte_val;
            if (nb_r == NB_OP)
                data_r <= byte_val;
            if (nb_r >= NB_OP && nb_r < NB_ADDR)
                addr_r <= {addr_r[15:0], byte_val};
            if (nb_r == NB_ADDR)
                conf_r <= byte_val;
        end
    end

    // ----------------------------------------
    // protection state
    // ----------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r   <= SPL_IDLE;
            cnt_r  <= 32'h0;
            wel_r  <= 1'b0;
            protection_regs_locked_bit_r <= PROTECTION_REGS_LOCKED_BIT_RST;
            sle_r  <= 1'b0;
            prot_r <= {NSECT{PROT_RST}};
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= (lock_go || frz_go) ? 32'(LOCK_CYCLES - 1) :
                      (cnt_r != 32'h0) ? cnt_r - 32'h1 : cnt_r;
            wel_r  <= wel_nxt;
            protection_regs_locked_bit_r <= protection_regs_locked_bit_nxt;
            sle_r  <= sle_nxt;
            prot_r <= prot_nxt;
        end
    end

    // nonvolatile image restored once after each reset release
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_r <= 1'b0;
            lock_r   <= {NSECT{1'b0}};
            frozen_r <= 1'b0;
            pe_r     <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
            lock_r   <= loaded_r ? lock_nxt : nv_lockdown_in;
            frozen_r <= loaded_r ? frozen_nxt : nv_frozen_in;
            pe_r     <= loaded_r & ~lock_r[pe_sector] & ~prot_r[pe_sector];
        end
    end

    assign sector_prot                = prot_r;
    assign lockdown_bits              = lock_r;
    assign frozen                     = frozen_r;
    assign write_enable_latch         = wel_r;
    assign protection_regs_locked_bit = protection_regs_locked_bit_r;
    assign lockdown_enable_bit        = sle_r;
    assign hw_locked                  = hw_lk;
    assign sw_locked                  = sw_lk;
    assign busy                       = (st_r == SPL_BUSY);
    assign pe_allowed                 = pe_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_lock_req;
        exec && op_r == OP_LOCKDN && lk_en && wel_r && fr_conf;
    endsequence
    sequence s_lock_bad;
        exec && op_r == OP_LOCKDN && !lock_go;
    endsequence

    hw_freeze_a: assert property (@(posedge mclk) disable iff (!arst_n)
        hw_lk |=> $stable(prot_r) && $stable(protection_regs_locked_bit_r))
        else $error("protection changed under hardware lock");
    clr_no_gp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $fell(protection_regs_locked_bit_r) |-> $stable(prot_r))
        else $error("global op while clearing lock bit");
    sw_freeze_a: assert property (@(posedge mclk) disable iff (!arst_n)
        sw_lk |=> $stable(prot_r))
        else $error("protection changed under software lock");
    gp_prot_a: assert property (@(posedge mclk) disable iff (!arst_n)
        gp_go && gp_code == GP_PROT |=> (&prot_r) && busy == 1'b0)
        else $error("global protect missed");
    lock_mono_a: assert property (@(posedge mclk) disable iff (!arst_n)
        loaded_r |=> ((lock_r & $past(lock_r)) == $past(lock_r)))
        else $error("lockdown bit cleared");
    lock_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_lock_req |=> busy && !wel_r && lock_r == ($past(lock_r) | $past(sect_oh)))
        else $error("lockdown not applied");
    lock_abort_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_lock_bad |=> $stable(lock_r) && $stable(sle_r) && !wel_r && !busy)
        else $error("aborted lockdown changed state");
    frz_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
        frozen_r && loaded_r |=> frozen_r && !sle_r)
        else $error("freeze not permanent");
    bound_abort_a: assert property (@(posedge mclk) disable iff (!arst_n)
        exec && !bound |=> $stable(prot_r) && $stable(lock_r) && $stable(protection_regs_locked_bit_r))
        else $error("off-boundary release acted");
    // a refused lockdown still drops the write enable latch
    sequence s_lock_off;
        exec && op_r == OP_LOCKDN && !lk_en;
    endsequence
    lock_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_lock_off |=> $stable(lock_r) && !wel_r && !busy)
        else $error("disabled lockdown acted");
    gp_unprot_a: assert property (@(posedge mclk) disable iff (!arst_n)
        gp_go && gp_code == GP_UNPROT |=> prot_r == {NSECT{1'b0}})
        else $error("global unprotect missed");
    pe_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
        loaded_r && lock_r[pe_sector] |=> !pe_r)
        else $error("locked sector allowed program");
endmodule

// ### spl_host_model.sv
module spl_host_model
    import spl_pkg::*;
(
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // ----------------------------------------
    // one frame, msb first, sclk idles low
    // ----------------------------------------
    // d is left aligned; nbits may stop off a byte boundary on purpose
    task automatic frame(input logic [47:0] d, input int nbits);
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            mosi = d[47-i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        // released line must not keep showing the last bit
        mosi = ~mosi;
        #1000;
    endtask

    // write enable always precedes a write command
    task automatic wr_cmd(input logic [47:0] d, input int nbits);
        frame({OP_WREN, 40'h0}, 8);
        frame(d, nbits);
    endtask
endmodule

// ### testbench.sv
module testbench
    import spl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sclk, cs_n, mosi;
    logic        wp_n = 1'b1;
    logic [15:0] nv_img = 16'h0000;
    logic        nv_frz = 1'b0;
    logic [3:0]  pe_sector = 4'h0;
    logic [15:0] sector_prot, lockdown_bits;
    logic        frozen, write_enable_latch, protection_regs_locked_bit;
    logic        lockdown_enable_bit, hw_locked, sw_locked, busy, pe_allowed;
    logic        saw_busy = 1'b0;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (busy === 1'b1) saw_busy <= 1'b1;

    spl_host_model i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

    spl_lockdown #(.SECT_W(4), .LOCK_CYCLES(20)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
        .nv_lockdown_in(nv_img), .nv_frozen_in(nv_frz), .pe_sector(pe_sector),
        .sector_prot(sector_prot), .lockdown_bits(lockdown_bits), .frozen(frozen),
        .write_enable_latch(write_enable_latch), .protection_regs_locked_bit(protection_regs_locked_bit),
        .lockdown_enable_bit(lockdown_enable_bit), .hw_locked(hw_locked), .sw_locked(sw_locked),
        .busy(busy), .pe_allowed(pe_allowed));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // power cycle: nonvolatile images follow what the block last held
    task automatic do_reset();
        tick(1);
        nv_img = lockdown_bits;
        nv_frz = frozen;
        arst_n = 1'b0;
        tick(4);
        arst_n = 1'b1;
        tick(5);
    endtask

    task automatic pe_chk(input logic [3:0] s, input logic exp);
        pe_sector = s;
        tick(3);
        chk(pe_allowed, exp);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        close_out();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        tick(4);
        arst_n = 1'b1;
        tick(5);
        chk(sector_prot, 16'hFFFF);
        chk(protection_regs_locked_bit, 1'b0);
        i_host.frame({OP_WREN, 40'h0}, 8);
        chk(write_enable_latch, 1'b1);
        i_host.frame({OP_WRDI, 40'h0}, 8);
        chk(write_enable_latch, 1'b0);
        i_host.frame({OP_WRSR1, 8'h00, 32'h0}, 16);
        chk(sector_prot, 16'hFFFF);
        i_host.wr_cmd({OP_WRSR1, 8'h00, 32'h0}, 16);
        chk(sector_prot, 16'h0000);
        chk(write_enable_latch, 1'b0);
        i_host.wr_cmd({OP_PROT, 24'h03ABCD, 16'h0}, 32);
        chk(sector_prot, 16'h0008);
        pe_chk(4'h3, 1'b0);
        pe_chk(4'h2, 1'b1);
        i_host.wr_cmd({OP_WRSR1, 8'hFC, 32'h0}, 16);
        chk(sector_prot, 16'hFFFF);
        chk(protection_regs_locked_bit, 1'b1);
        chk({hw_locked, sw_locked}, 2'b01);
        i_host.wr_cmd({OP_UNPROT, 24'h030000, 16'h0}, 32);
        chk(sector_prot, 16'hFFFF);
        i_host.wr_cmd({OP_WRSR1, 8'h00, 32'h0}, 16);
        chk(protection_regs_locked_bit, 1'b0);
        chk(sector_prot, 16'hFFFF);
        $display("test protection states done");

        wp_n = 1'b0;
        i_host.wr_cmd({OP_WRSR1, 8'hF0, 32'h0}, 16);
        chk({hw_locked, sw_locked, protection_regs_locked_bit}, 3'b101);
        i_host.wr_cmd({OP_WRSR1, 8'h00, 32'h0}, 16);
        chk(protection_regs_locked_bit, 1'b1);
        i_host.wr_cmd({OP_UNPROT, 24'h000000, 16'h0}, 32);
        chk(sector_prot, 16'hFFFF);
        pe_chk(4'h0, 1'b0);
        do_reset();
        chk({hw_locked, protection_regs_locked_bit}, 2'b00);
        wp_n = 1'b1;
        $display("test hardware lock done");

        i_host.wr_cmd({OP_LOCKDN, 24'h050000, CONFIRM, 8'h0}, 40);
        chk(lockdown_bits, 16'h0000);
        chk(write_enable_latch, 1'b0);
        i_host.wr_cmd({OP_WRSR2, 8'h10, 32'h0}, 16);
        chk(lockdown_enable_bit, 1'b1);
        i_host.wr_cmd({OP_LOCKDN, 24'h05F0F0, CONFIRM, 8'h0}, 40);
        chk(lockdown_bits, 16'h0020);
        chk({write_enable_latch, saw_busy}, 2'b01);
        i_host.wr_cmd({OP_LOCKDN, 24'h060000, 8'h11, 8'h0}, 40);
        chk(lockdown_bits, 16'h0020);
        i_host.wr_cmd({OP_LOCKDN, 24'h060000, CONFIRM, 8'h0}, 32);
        chk(lockdown_bits, 16'h0020);
        i_host.wr_cmd({OP_LOCKDN, 24'h060000, CONFIRM, 8'hFF}, 43);
        chk(lockdown_bits, 16'h0020);
        chk({write_enable_latch, lockdown_enable_bit}, 2'b01);
        i_host.wr_cmd({OP_LOCKDN, 24'h060000, CONFIRM, 8'h5A}, 48);
        chk(lockdown_bits, 16'h0060);
        i_host.wr_cmd({OP_WRSR1, 8'h00, 32'h0}, 16);
        pe_chk(4'h5, 1'b0);
        pe_chk(4'h7, 1'b1);
        do_reset();
        chk(lockdown_bits, 16'h0060);
        $display("test lockdown done");

        i_host.wr_cmd({OP_WRSR2, 8'h10, 32'h0}, 16);
        i_host.wr_cmd({OP_FREEZE, FREEZE_ADR, CONFIRM, 8'h0}, 40);
        chk({frozen, lockdown_enable_bit}, 2'b10);
        i_host.wr_cmd({OP_WRSR2, 8'h10, 32'h0}, 16);
        chk(lockdown_enable_bit, 1'b0);
        i_host.wr_cmd({OP_LOCKDN, 24'h080000, CONFIRM, 8'h0}, 40);
        chk(lockdown_bits, 16'h0060);
        do_reset();
        chk(frozen, 1'b1);
        chk(lockdown_bits, 16'h0060);
        $display("test freeze done");
        close_out();
    end
endmodule
